/* File: rtl/i2ctt_pkg.sv */
// Constants for the I2C target-transmit status block
package i2ctt_pkg;
  // Register byte offsets (Avalon-MM, one 32-bit word each)
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_OWN_ADDR = 5'h0C;
  localparam logic [4:0] OFS_INT_STAT = 5'h10;
  localparam logic [4:0] OFS_INT_CLR = 5'h14;
  localparam logic [4:0] OFS_INT_EN = 5'h18;
  // ctrl_flags_reg field positions
  localparam int CTRL_ACK_ASSERT = 0;
  localparam int CTRL_BUS_RELEASE = 1;
  localparam int CTRL_BEGIN_REQ = 2;
  localparam int CTRL_IRQ_FLAG = 3;
  // Interrupt status bit positions
  localparam int INT_SERVICE = 0;
  localparam int INT_BUS_ERROR = 1;
  // Reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [1:0] INT_EN_RESET = 2'h0;
  // Condition codes
  localparam logic [7:0] CODE_OWN_READ = 8'hA8;
  localparam logic [7:0] CODE_ARB_READ = 8'hB0;
  localparam logic [7:0] CODE_TX_ACK = 8'hB8;
  localparam logic [7:0] CODE_TX_NACK = 8'hC0;
  localparam logic [7:0] CODE_LAST_ACK = 8'hC8;
  localparam logic [7:0] CODE_NO_INFO = 8'hF8;
  localparam logic [7:0] CODE_BUS_ERROR = 8'h00;
  // Bits in one byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] GC_ADDRESS = 7'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_TX_WAIT = 3'b011,
    ST_TX_BIT = 3'b100,
    ST_TX_ACK = 3'b101,
    ST_DONE = 3'b110,
    ST_ERROR = 3'b111
  } i2ctt_state_t;
endpackage

/* File: rtl/i2ctt_target_tx.sv */
// I2C addressed target transmitter with status codes and register slave
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - Own address with read acknowledged: set irq_flag, code 0xA8.
// R2 - In 0xA8/B0/B8 software loads byte, clears irq_flag; byte is sent, ack sampled.
// R3 - Clearing irq_flag with ack_assert low sends the byte as the last one.
// R4 - Arbitration lost as master then addressed for read reports 0xB0.
// R5 - Byte sent and acknowledged: set irq_flag, code 0xB8.
// R6 - Last byte acknowledged gives 0xC8; a not-acknowledged byte gives 0xC0.
// R7 - Leaving 0xC0/C8 with begin_request and ack_assert low: ignore all addresses.
// R8 - Leaving with ack_assert high: recognise own address, general call if bit 0 set.
// R9 - Leaving with begin_request high: issue START once the bus is free.
// R10 - Code 0xF8 is shown whenever irq_flag is clear.
// R11 - 0xF8 shows between defined states and when not in a transfer.
// R12 - START or STOP at an illegal frame position reports bus error 0x00.
// R13 - Disturbed internal state is also treated as bus error 0x00.
// R14 - A bus error sets irq_flag.
// R15 - Software recovers by setting bus_release_request while clearing irq_flag.
// R16 - Recovery: not addressed, clear only bus_release_request, release lines, no STOP.
// R17 - Transmit is entered only when the direction bit after the address is one.
// R18 - While irq_flag is set in an addressed state, hold the clock low.
module i2ctt_target_tx (
  input wire logic i_sys_clk, // System clock, 100 MHz
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic [4:0] i_avs_address, // Avalon byte address
  input wire logic i_avs_read, // Avalon read request
  input wire logic i_avs_write, // Avalon write request
  input wire logic [31:0] i_avs_writedata, // Avalon write data
  output logic [31:0] o_avs_readdata, // Avalon read data
  output logic o_avs_waitrequest, // Avalon wait request
  input wire logic i_scl_in, // Serial clock line level
  output logic o_scl_out, // Serial clock drive value
  output logic o_scl_oe, // Serial clock drive enable
  input wire logic i_sda_in, // Serial data line level
  output logic o_sda_out, // Serial data drive value
  output logic o_sda_oe, // Serial data drive enable
  input wire logic i_arb_lost, // Pulse: master logic lost arbitration
  output logic o_start_strobe, // Pulse: request a START to master logic
  output logic o_irq // Level interrupt
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_s1;
  logic rst_n;
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= i_scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  // Data edges only count while the clock stays high
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave
  i2ctt_pkg::i2ctt_state_t state;
  logic ack_assert;
  logic bus_release_request;
  logic begin_request;
  logic irq_flag;
  logic [7:0] byte_buffer_reg;
  logic [7:0] own_addr_reg;
  logic [7:0] code;
  logic [1:0] int_stat;
  logic [1:0] int_en;
  logic acc;
  logic bus_busy;
  logic arb_pending;
  logic last_byte;
  logic got_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;

  wire req = (i_avs_read | i_avs_write) & o_avs_waitrequest & ~acc;
  // A write takes effect on the edge where waitrequest is seen low
  wire wr_now = i_avs_write & acc;
  wire wr_ctrl = wr_now & (i_avs_address == i2ctt_pkg::OFS_CTRL);
  wire wr_data = wr_now & (i_avs_address == i2ctt_pkg::OFS_DATA);
  wire wr_own = wr_now & (i_avs_address == i2ctt_pkg::OFS_OWN_ADDR);
  wire wr_iclr = wr_now & (i_avs_address == i2ctt_pkg::OFS_INT_CLR);
  wire wr_ien = wr_now & (i_avs_address == i2ctt_pkg::OFS_INT_EN);
  wire w_aa = i_avs_writedata[i2ctt_pkg::CTRL_ACK_ASSERT];
  wire w_sto = i_avs_writedata[i2ctt_pkg::CTRL_BUS_RELEASE];
  wire w_sta = i_avs_writedata[i2ctt_pkg::CTRL_BEGIN_REQ];
  // Writing one to the flag position services the pending code
  wire svc = wr_ctrl & i_avs_writedata[i2ctt_pkg::CTRL_IRQ_FLAG] & irq_flag;

  wire [7:0] status_view = irq_flag ? code : i2ctt_pkg::CODE_NO_INFO; // R10 R11
  wire [3:0] ctrl_view = {irq_flag, begin_request, bus_release_request,
                          ack_assert};
  wire [31:0] rd_mux =
    (i_avs_address == i2ctt_pkg::OFS_CTRL) ? {28'h0000000, ctrl_view} :
    (i_avs_address == i2ctt_pkg::OFS_STATUS) ? {24'h000000, status_view} :
    (i_avs_address == i2ctt_pkg::OFS_DATA) ? {24'h000000, byte_buffer_reg} :
    (i_avs_address == i2ctt_pkg::OFS_OWN_ADDR) ? {24'h000000, own_addr_reg} :
    (i_avs_address == i2ctt_pkg::OFS_INT_STAT) ? {30'h0, int_stat} :
    (i_avs_address == i2ctt_pkg::OFS_INT_EN) ? {30'h0, int_en} :
    32'h00000000;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      acc <= req;
      o_avs_waitrequest <= ~req;
      o_avs_readdata <= req ? rd_mux : o_avs_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address recognition and frame events
  wire gc_enable = own_addr_reg[0];
  // General call is recognised, but it is a write and never opens transmit
  wire addr_hit = (shreg[7:1] == own_addr_reg[7:1]) |
                  (gc_enable & (shreg[7:1] == i2ctt_pkg::GC_ADDRESS)); // R8
  wire gc_read = (shreg[7:1] == i2ctt_pkg::GC_ADDRESS);
  wire read_hit = addr_hit & shreg[0] & ~gc_read; // R17
  wire in_frame = (state == i2ctt_pkg::ST_ADDR_ACK) |
                  (state == i2ctt_pkg::ST_TX_BIT) |
                  (state == i2ctt_pkg::ST_TX_ACK) |
                  ((state == i2ctt_pkg::ST_ADDR) && (bit_cnt != 4'h0));
  wire frame_err = in_frame & (bus_start | bus_stop); // R12
  wire ack_done = (state == i2ctt_pkg::ST_ADDR_ACK) & scl_fall;
  wire tx_done = (state == i2ctt_pkg::ST_TX_ACK) & scl_fall;
  wire set_irq = ack_done | tx_done | frame_err;
  wire [7:0] tx_code = ~got_ack ? i2ctt_pkg::CODE_TX_NACK : // R6
                       last_byte ? i2ctt_pkg::CODE_LAST_ACK : // R6
                       i2ctt_pkg::CODE_TX_ACK; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Control flags and codes
  logic err_event;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_assert <= i2ctt_pkg::CTRL_RESET[i2ctt_pkg::CTRL_ACK_ASSERT];
      bus_release_request <= i2ctt_pkg::CTRL_RESET[i2ctt_pkg::CTRL_BUS_RELEASE];
      begin_request <= i2ctt_pkg::CTRL_RESET[i2ctt_pkg::CTRL_BEGIN_REQ];
      irq_flag <= i2ctt_pkg::CTRL_RESET[i2ctt_pkg::CTRL_IRQ_FLAG];
      byte_buffer_reg <= 8'h00;
      own_addr_reg <= i2ctt_pkg::OWN_ADDR_RESET;
      code <= i2ctt_pkg::CODE_NO_INFO;
      arb_pending <= 1'b0;
      bus_busy <= 1'b0;
      o_start_strobe <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      irq_flag <= set_irq | err_event | (irq_flag & ~svc); // R14
      if (set_irq | err_event) begin
        code <= (frame_err | err_event) ? i2ctt_pkg::CODE_BUS_ERROR : // R12 R13
                tx_done ? tx_code :
                arb_pending ? i2ctt_pkg::CODE_ARB_READ : // R4
                i2ctt_pkg::CODE_OWN_READ; // R1
      end
      if (wr_ctrl) begin
        ack_assert <= w_aa;
        begin_request <= w_sta;
        bus_release_request <= w_sto;
      end
      // Recovery clears only the release request among the flags
      if (svc && (state == i2ctt_pkg::ST_ERROR) && w_sto) begin
        bus_release_request <= 1'b0; // R16
      end
      o_start_strobe <= 1'b0;
      if (!wr_ctrl && begin_request && !bus_busy &&
          (state == i2ctt_pkg::ST_IDLE)) begin
        o_start_strobe <= 1'b1; // R9
        begin_request <= 1'b0;
      end
      if (wr_data) begin
        byte_buffer_reg <= i_avs_writedata[7:0];
      end
      if (wr_own) begin
        own_addr_reg <= i_avs_writedata[7:0];
      end
      if (i_arb_lost) begin
        arb_pending <= 1'b1;
      end else if (ack_done | (state == i2ctt_pkg::ST_IDLE & bus_stop)) begin
        arb_pending <= 1'b0;
      end
      if (bus_start) begin
        bus_busy <= 1'b1;
      end else if (bus_stop) begin
        bus_busy <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial state machine
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= i2ctt_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      last_byte <= 1'b0;
      got_ack <= 1'b0;
      err_event <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_oe <= 1'b0;
    end else begin
      err_event <= 1'b0;
      if (frame_err) begin
        state <= i2ctt_pkg::ST_ERROR; // R12
        o_sda_oe <= 1'b0;
        o_scl_oe <= 1'b0;
      end else begin
        case (state)
          i2ctt_pkg::ST_IDLE: begin
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
            // With ack_assert low the bus is only watched
            if (bus_start && ack_assert) begin // R7 R8
              state <= i2ctt_pkg::ST_ADDR;
              bit_cnt <= 4'h0;
            end
          end
          i2ctt_pkg::ST_ADDR: begin
            if (bus_stop) begin
              state <= i2ctt_pkg::ST_IDLE;
            end else if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && (bit_cnt == i2ctt_pkg::BYTE_BITS)) begin
              if (read_hit) begin // R17
                state <= i2ctt_pkg::ST_ADDR_ACK;
                o_sda_oe <= 1'b1;
              end else begin
                state <= i2ctt_pkg::ST_IDLE;
              end
            end
          end
          i2ctt_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              o_scl_oe <= 1'b1; // R18
              state <= i2ctt_pkg::ST_TX_WAIT; // R1 R4
            end
          end
          i2ctt_pkg::ST_TX_WAIT: begin
            if (svc) begin
              // The first bit goes out on the same edge that lets the clock go
              shreg <= byte_buffer_reg; // R2
              o_sda_oe <= ~byte_buffer_reg[7];
              last_byte <= ~w_aa; // R3
              bit_cnt <= 4'h0;
              o_scl_oe <= 1'b0;
              state <= i2ctt_pkg::ST_TX_BIT;
            end
          end
          i2ctt_pkg::ST_TX_BIT: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == i2ctt_pkg::BYTE_BITS) begin
                o_sda_oe <= 1'b0;
                state <= i2ctt_pkg::ST_TX_ACK;
              end else begin
                shreg <= {shreg[6:0], 1'b1};
                o_sda_oe <= ~shreg[6];
              end
            end
          end
          i2ctt_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              got_ack <= ~sda_s2; // R2 R3
            end else if (scl_fall) begin
              o_scl_oe <= 1'b1; // R18
              if (got_ack && !last_byte) begin
                state <= i2ctt_pkg::ST_TX_WAIT; // R5
              end else begin
                state <= i2ctt_pkg::ST_DONE; // R6
              end
            end
          end
          i2ctt_pkg::ST_DONE: begin
            // Lines released on leave; a continuing master reads ones
            if (svc) begin
              o_scl_oe <= 1'b0;
              state <= i2ctt_pkg::ST_IDLE; // R7 R8 R9
            end
          end
          i2ctt_pkg::ST_ERROR: begin
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
            if (svc && w_sto) begin
              state <= i2ctt_pkg::ST_IDLE; // R15 R16
            end
          end
          default: begin
            err_event <= 1'b1; // R13
            state <= i2ctt_pkg::ST_ERROR;
            o_sda_oe <= 1'b0;
            o_scl_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, clear and enable
  wire [1:0] int_event = {frame_err | err_event, set_irq & ~frame_err};

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= 2'h0;
      int_en <= i2ctt_pkg::INT_EN_RESET;
      o_irq <= 1'b0;
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      // Events win over a clear in the same cycle
      int_stat <= int_event | (int_stat & ~(wr_iclr ?
                  i_avs_writedata[1:0] : 2'h0));
      if (wr_ien) begin
        int_en <= i_avs_writedata[1:0];
      end
      o_irq <= |(int_stat & int_en);
      // Open-drain lines only ever pull low
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: bench/i2ctt_properties.sv */
// Port-level assertions for the I2C target-transmit block
`timescale 1ns/1ps
`default_nettype none
module i2ctt_properties (
  input wire logic i_sys_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic [4:0] i_avs_address, // Address
  input wire logic i_avs_read, // Read
  input wire logic i_avs_write, // Write
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic o_avs_waitrequest, // Wait
  input wire logic i_scl_in, // Clock wire
  input wire logic o_scl_out, // Clock value
  input wire logic o_scl_oe, // Clock enable
  input wire logic o_sda_out, // Data value
  input wire logic o_sda_oe, // Data enable
  input wire logic o_start_strobe // START request
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Control write that clears the flag, at the edge where it lands
  wire logic clr_wr = i_avs_write && !o_avs_waitrequest &&
    i_avs_address == 5'h00 && i_avs_writedata[3];
  //////////////////////////////////////////////////////////////////////////
  a_bus_answer: assert property ((i_avs_read || i_avs_write) |->
    ##[0:2] !o_avs_waitrequest) else $error("no bus answer");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  // Release may land one edge after the write, hence the past term
  a_stretch_hold: assert property (
    o_scl_oe && !clr_wr && !$past(clr_wr) |=> o_scl_oe)
    else $error("clock released unserviced");
  a_release_lines: assert property (
    clr_wr && i_avs_writedata[1] |-> ##[1:3] (!o_scl_oe && !o_sda_oe))
    else $error("lines held after recovery");
  a_sda_on_low: assert property (
    $changed(o_sda_oe) |-> !$past(i_scl_in))
    else $error("data moved with clock high");
  a_strobe_pulse: assert property (
    o_start_strobe |=> !o_start_strobe) else $error("long start pulse");
  a_strobe_free: assert property (
    o_start_strobe |-> i_scl_in && !o_scl_oe && !o_sda_oe)
    else $error("start while bus held");
  a_open_drain: assert property (!o_scl_out && !o_sda_out)
    else $error("line driven high");
  c_stretch: cover property ($fell(o_scl_oe));
  c_strobe: cover property (o_start_strobe);
  c_recover: cover property (clr_wr && i_avs_writedata[1]);
endmodule
bind i2ctt_target_tx i2ctt_properties i_i2ctt_properties (.i_sys_clk,
  .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .o_avs_waitrequest, .i_scl_in, .o_scl_out, .o_scl_oe, .o_sda_out,
  .o_sda_oe, .o_start_strobe);
`default_nettype wire

/* File: bench/i2ctt_mst.sv */
// Behavioural I2C bus master working as receiver on the far side
`timescale 1ns/1ps
`default_nettype none
module i2ctt_mst (
  input wire logic i_scl, // Clock wire level
  input wire logic i_sda, // Data wire level
  output logic o_scl, // Clock drive, low pulls the wire
  output logic o_sda // Data drive, low pulls the wire
);
  initial {o_scl, o_sda} = 2'h3;
  // Target may stretch the low phase; bounded so a hang hits the timeout
  task automatic rise();
    o_scl = 1'h1;
    for (int k = 0; k < 20000 && i_scl !== 1'h1; k++) #10;
  endtask
  // Long low phase leaves the target room to stretch before the rise
  task automatic clk_bit(input logic b, output logic s);
    o_sda = b;
    #45;
    rise();
    #30;
    s = i_sda;
    o_scl = 1'h0;
    #5;
  endtask
  // START when s is 1, STOP when s is 0
  task automatic cond(input logic s);
    o_sda = s;
    #45;
    rise();
    #40;
    o_sda = ~s;
    #40;
    o_scl = ~s;
    #5;
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(v[i], ack);
    clk_bit(1'h1, ack);
  endtask
  task automatic recv(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'h1, d[i]);
    clk_bit(mack, s);
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the I2C target-transmit block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] a; logic ack; logic mack;
    logic [7:0] code;} i2ctt_row_t;
  logic clk, rst_n, rd, wr, arb;
  logic [4:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata, q;
  logic waitreq, scl_oe, sda_oe, strobe, irq, m_scl, m_sda, ack;
  logic scl_out, sda_out;
  logic [7:0] d;
  int num_errors = 0, checked = 0, cycles = 0, strobes = 0;
  // Address byte, expected ack level, master ack of first byte, end code
  i2ctt_row_t rows [5] = '{'{8'h85, 1'h0, 1'h0, 8'hC8},
    '{8'h85, 1'h0, 1'h1, 8'hC0}, '{8'h84, 1'h1, 1'h1, 8'hF8},
    '{8'h87, 1'h1, 1'h1, 8'hF8}, '{8'h01, 1'h1, 1'h1, 8'hF8}};
  logic [4:0] regs [6] = '{5'h00, 5'h04, 5'h0C, 5'h14, 5'h18, 5'h1C};
  logic [31:0] vals [6] = '{32'h0, 32'hF8, 32'h0, 32'h0, 32'h0, 32'h0};
  wire logic scl = m_scl & ~scl_oe;
  wire logic sda = m_sda & ~sda_oe;
  i2ctt_target_tx i_i2ctt_target_tx (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_scl_in(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_sda_in(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_arb_lost(arb),
    .o_start_strobe(strobe), .o_irq(irq));
  i2ctt_mst i_i2ctt_mst (.i_scl(scl), .i_sda(sda), .o_scl(m_scl),
    .o_sda(m_sda));
  ////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (strobe === 1'h1)
      strobes <= strobes + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= v;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (waitreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    check(q, e);
  endtask
  task automatic wait_code(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      bus(1'h0, 5'h04, 32'h0);
      n++;
    end while (q[7:0] === 8'hF8 && n < 40);
    check(q, {24'h0, e});
  endtask
  task automatic addr_phase(input logic [7:0] a);
    i_i2ctt_mst.cond(1'h1);
    i_i2ctt_mst.send(a, ack);
  endtask
  // Byte and flag clear go in while the master waits on the held clock
  task automatic serve(input logic [7:0] b, input logic aa, input logic m);
    fork
      i_i2ctt_mst.recv(m, d);
      begin
        bus(1'h1, 5'h08, {24'h0, b});
        bus(1'h1, 5'h00, {28'h0, 3'h4, aa});
      end
    join
    check(32'(d), 32'(b));
  endtask
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    {rd, wr, arb, addr, wdata} = 40'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    bus(1'h1, 5'h04, 32'h0);
    for (int i = 0; i < 6; i++)
      rd_chk(regs[i], vals[i]);
    $display("reset values done");
    bus(1'h1, 5'h0C, 32'h85);
    bus(1'h1, 5'h00, 32'h1);
    for (int r = 0; r < 5; r++) begin
      addr_phase(rows[r].a);
      check(32'(ack), 32'(rows[r].ack));
      if (ack === 1'h0) begin
        wait_code(8'hA8);
        serve(8'hA5, 1'h1, rows[r].mack);
        if (rows[r].mack === 1'h0) begin
          wait_code(8'hB8);
          serve(8'h3C, 1'h0, 1'h0);
        end
        wait_code(rows[r].code);
        bus(1'h1, 5'h00, 32'h9);
        rd_chk(5'h04, 32'hF8);
      end
      i_i2ctt_mst.cond(1'h0);
      $display("row %0d done", r);
    end
    rd_chk(5'h10, 32'h1);
    check(32'(irq), 32'h0);
    bus(1'h1, 5'h18, 32'h3);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    bus(1'h1, 5'h14, 32'h1);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    rd_chk(5'h10, 32'h0);
    $display("interrupt done");
    addr_phase(8'h85);
    wait_code(8'hA8);
    serve(8'h5A, 1'h0, 1'h0);
    wait_code(8'hC8);
    bus(1'h1, 5'h00, 32'h8);
    i_i2ctt_mst.cond(1'h0);
    addr_phase(8'h85);
    check(32'(ack), 32'h1);
    i_i2ctt_mst.cond(1'h0);
    bus(1'h1, 5'h00, 32'h1);
    $display("not addressed done");
    @(posedge clk);
    arb <= 1'h1;
    @(posedge clk);
    arb <= 1'h0;
    addr_phase(8'h85);
    wait_code(8'hB0);
    serve(8'hC3, 1'h0, 1'h1);
    wait_code(8'hC0);
    bus(1'h1, 5'h00, 32'hD);
    i_i2ctt_mst.cond(1'h0);
    repeat (20) @(posedge clk);
    check(32'(strobes), 32'h1);
    $display("arbitration done");
    i_i2ctt_mst.cond(1'h1);
    repeat (3) i_i2ctt_mst.clk_bit(1'h1, ack);
    i_i2ctt_mst.cond(1'h1);
    wait_code(8'h00);
    bus(1'h0, 5'h10, 32'h0);
    check(32'(q[1]), 32'h1);
    bus(1'h1, 5'h00, 32'hB);
    rd_chk(5'h00, 32'h1);
    rd_chk(5'h04, 32'hF8);
    check({30'h0, scl_out, sda_out}, 32'h0);
    i_i2ctt_mst.cond(1'h0);
    $display("bus error done");
    final_report();
  end
endmodule
`default_nettype wire
